/* pjs_sequencer.sv */
`timescale 1ns/1ps
module pjs_sequencer
#(
	parameter int unsigned TICK_CYCLES = pjs_pkg::CYCLES_PER_MS
)
(
	input  wire logic               ref_clk,
	input  wire logic               rst,
	input  wire logic               util_selected,
	input  wire logic               key_shift,
	input  wire logic               key_mode,
	input  wire logic               param_write_ok,
	input  wire logic               main_power_on,
	input  wire logic               servo_on,
	input  wire logic               safe_state,
	input  wire logic               alarm,
	input  wire logic               overtravel,
	input  wire logic signed [7:0]  first_pattern_turns,
	input  wire logic [11:0]        first_pattern_peak_speed,
	input  wire logic [10:0]        first_pattern_ramp_time,
	input  wire logic [13:0]        first_pattern_dwell_time,
	input  wire logic signed [7:0]  second_pattern_turns,
	input  wire logic [11:0]        second_pattern_peak_speed,
	input  wire logic [10:0]        second_pattern_ramp_time,
	input  wire logic [13:0]        second_pattern_dwell_time,
	output logic                    util_open,
	output logic                    running,
	output logic                    refused,
	output logic                    pattern_sel,
	output logic                    reverse,
	output logic signed [12:0]      speed_ref,
	output logic signed [31:0]      pos_ref
);
	//------------------------------------------------------------
	// setting clamps
	//------------------------------------------------------------
	function automatic logic [13:0] clamp_u(input logic [13:0] v,
		input logic [13:0] lo, input logic [13:0] hi);
		if (v < lo)
			return lo;
		else if (v > hi)
			return hi;
		return v;
	endfunction

	logic               ms_tick;
	logic               permit;
	logic signed [7:0]  turns_raw;
	logic [6:0]         turns_mag;
	logic [11:0]        peak;
	logic [10:0]        ramp;
	logic [13:0]        dwell;
	logic [11:0]        step;
	logic [31:0]        travel;
	logic [31:0]        brake_dist;

	pjs_ms_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick
	(
		.ref_clk (ref_clk),
		.rst     (rst),
		.ms_tick (ms_tick)
	);

	pjs_pkg::pjs_state_e state;
	pjs_pkg::pjs_state_e next_state;
	logic [11:0]        spd;
	logic [11:0]        next_spd;
	logic [31:0]        done;
	logic [31:0]        next_done;
	logic [13:0]        ms_cnt;
	logic [13:0]        next_ms_cnt;
	logic               next_pattern_sel;
	logic signed [31:0] next_pos_ref;

	// settings are read live from the active pattern every cycle
	always_comb
	begin
		turns_raw = pattern_sel ? second_pattern_turns
			: first_pattern_turns;
		if (turns_raw < pjs_pkg::TURNS_MIN)
			turns_raw = pjs_pkg::TURNS_MIN;
		else if (turns_raw > pjs_pkg::TURNS_MAX)
			turns_raw = pjs_pkg::TURNS_MAX;
		turns_mag = turns_raw[7] ? 7'(-turns_raw) : 7'(turns_raw);
		peak = 12'(clamp_u(14'(pattern_sel ? second_pattern_peak_speed
			: first_pattern_peak_speed), 14'(pjs_pkg::SPEED_MIN),
			14'(pjs_pkg::SPEED_MAX)));
		ramp = 11'(clamp_u(14'(pattern_sel ? second_pattern_ramp_time
			: first_pattern_ramp_time), 14'(pjs_pkg::RAMP_MIN),
			14'(pjs_pkg::RAMP_MAX)));
		dwell = clamp_u(pattern_sel ? second_pattern_dwell_time
			: first_pattern_dwell_time, pjs_pkg::DWELL_MIN,
			pjs_pkg::DWELL_MAX);
		step = 12'(({12'h0, peak} + {13'h0, ramp} - 24'h1) / {13'h0, ramp});
		if (step == 12'h0)
			step = 12'h1;
		travel = 32'(turns_mag) * pjs_pkg::POS_PER_TURN;
		// distance to stop from current speed, v*v/(2*step) approx
		brake_dist = 32'((32'(spd) * 32'(spd + step)) / (32'(step) * 2));
	end

	assign permit = param_write_ok && main_power_on && !servo_on
		&& !safe_state;
	assign refused = util_open && key_mode && state == pjs_pkg::PJS_OPEN
		&& !(permit && !alarm && !overtravel);

	//------------------------------------------------------------
	// sequencer
	//------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_spd = spd;
		next_done = done;
		next_ms_cnt = ms_cnt;
		next_pattern_sel = pattern_sel;
		next_pos_ref = pos_ref;
		unique case (state)
		pjs_pkg::PJS_IDLE:
			if (util_selected && key_shift)
				next_state = pjs_pkg::PJS_OPEN;
		pjs_pkg::PJS_OPEN:
			if (key_shift)
				next_state = pjs_pkg::PJS_IDLE;
			else if (key_mode && !refused)
			begin
				next_state = pjs_pkg::PJS_ACCEL;
				next_pattern_sel = 1'b0;
				next_spd = '0;
				next_done = '0;
			end
		default:
		begin
			// drive faults abort motion mid-profile, not only at start
			if (key_shift || servo_on || alarm || overtravel
				|| !main_power_on || safe_state)
			begin
				next_state = key_shift ? pjs_pkg::PJS_IDLE
					: pjs_pkg::PJS_OPEN;
				next_spd = '0;
			end
			else if (ms_tick)
			begin
				if (state != pjs_pkg::PJS_DWELL)
				begin
					next_done = done + 32'(spd);
					next_pos_ref = reverse ? pos_ref - 32'(spd)
						: pos_ref + 32'(spd);
				end
				unique case (state)
				pjs_pkg::PJS_ACCEL:
					// turn around once this step plus the stop would
					// cover the travel; same test as in cruise
					if (done + 32'(spd) + brake_dist >= travel)
						next_state = pjs_pkg::PJS_DECEL;
					else if (spd + step >= peak)
					begin
						next_spd = peak;
						next_state = pjs_pkg::PJS_CRUISE;
					end
					else
						next_spd = spd + step;
				pjs_pkg::PJS_CRUISE:
					if (done + 32'(spd) + brake_dist >= travel)
						next_state = pjs_pkg::PJS_DECEL;
				pjs_pkg::PJS_DECEL:
					if (spd <= step || done >= travel)
					begin
						next_spd = '0;
						next_ms_cnt = '0;
						next_state = pjs_pkg::PJS_DWELL;
					end
					else
						next_spd = spd - step;
				pjs_pkg::PJS_DWELL:
					if (ms_cnt + 14'h1 >= dwell)
					begin
						next_pattern_sel = !pattern_sel;
						next_done = '0;
						next_state = pjs_pkg::PJS_ACCEL;
					end
					else
						next_ms_cnt = ms_cnt + 14'h1;
				default:
					next_state = pjs_pkg::PJS_IDLE;
				endcase
			end
		end
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			state <= pjs_pkg::PJS_IDLE;
			spd <= '0;
			done <= '0;
			ms_cnt <= '0;
			pattern_sel <= 1'b0;
			pos_ref <= '0;
		end
		else
		begin
			state <= next_state;
			spd <= next_spd;
			done <= next_done;
			ms_cnt <= next_ms_cnt;
			pattern_sel <= next_pattern_sel;
			pos_ref <= next_pos_ref;
		end
	end

	assign util_open = state != pjs_pkg::PJS_IDLE;
	assign running = util_open && state != pjs_pkg::PJS_OPEN;
	assign reverse = turns_raw[7];
	assign speed_ref = reverse ? -13'(spd) : 13'(spd);

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	a_refuse_blocks: assert property (@(posedge ref_clk) disable iff (rst)
		refused |=> !running) else $error("run started when refused");
	a_interlock_ok: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(running) |-> $past(permit)) else $error("run without permit");
	a_mode_starts: assert property (@(posedge ref_clk) disable iff (rst)
		state == pjs_pkg::PJS_OPEN && key_mode && !key_shift && !refused
		|=> running) else $error("mode key did not start");
	a_shift_leaves: assert property (@(posedge ref_clk) disable iff (rst)
		util_open && key_shift |=> !util_open)
		else $error("shift key did not leave");
	a_peak_limit: assert property (@(posedge ref_clk) disable iff (rst)
		spd <= pjs_pkg::SPEED_MAX) else $error("speed above limit");
	a_dwell_still: assert property (@(posedge ref_clk) disable iff (rst)
		state == pjs_pkg::PJS_DWELL |-> spd == 12'h0 ##1 $stable(pos_ref))
		else $error("motion during dwell");
	a_pattern_swap: assert property (@(posedge ref_clk) disable iff (rst)
		state == pjs_pkg::PJS_DWELL && next_state == pjs_pkg::PJS_ACCEL
		|=> pattern_sel != $past(pattern_sel))
		else $error("pattern did not alternate");
	a_dir_sign: assert property (@(posedge ref_clk) disable iff (rst)
		reverse && spd != 12'h0 |-> speed_ref < 0)
		else $error("reverse sign wrong");
	a_rev_travel: assert property (@(posedge ref_clk) disable iff (rst)
		running && ms_tick && reverse |=> pos_ref <= $past(pos_ref))
		else $error("reverse pattern moved forward");
	c_run: cover property (@(posedge ref_clk) $rose(running));
	c_swap: cover property (@(posedge ref_clk) $changed(pattern_sel));
	c_refuse: cover property (@(posedge ref_clk) refused);
	c_triangle: cover property (@(posedge ref_clk)
		state == pjs_pkg::PJS_ACCEL ##1 state == pjs_pkg::PJS_DECEL);
endmodule

/* pjs_pkg.sv */
package pjs_pkg;

	//------------------------------------------------------------
	// clock and time base
	//------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 200_000_000;
	localparam int unsigned MS_TIME       = 1;
	localparam int unsigned CYCLES_PER_MS = CLK_HZ / 1000 * MS_TIME;

	//------------------------------------------------------------
	// setting limits and reset values
	//------------------------------------------------------------
	localparam logic signed [7:0]  TURNS_MIN   = -8'sd50;
	localparam logic signed [7:0]  TURNS_MAX   = 8'sd50;
	localparam logic signed [7:0]  TURNS_RST   = 8'sd5;
	localparam logic [11:0]        SPEED_MIN   = 12'h064;
	localparam logic [11:0]        SPEED_MAX   = 12'hbb8;
	localparam logic [11:0]        SPEED_RST   = 12'h3e8;
	localparam logic [10:0]        RAMP_MIN    = 11'h032;
	localparam logic [10:0]        RAMP_MAX    = 11'h7d0;
	localparam logic [10:0]        RAMP_RST    = 11'h1f4;
	localparam logic [13:0]        DWELL_MIN   = 14'h0064;
	localparam logic [13:0]        DWELL_MAX   = 14'h2710;
	localparam logic [13:0]        DWELL_RST   = 14'h03e8;

	//------------------------------------------------------------
	// position scale: rpm*ms summed per ms, 60000 per rotation
	//------------------------------------------------------------
	localparam logic [31:0] POS_PER_TURN = 32'h0000ea60;

	typedef enum logic [2:0]
	{
		PJS_IDLE  = 3'b000,
		PJS_OPEN  = 3'b001,
		PJS_ACCEL = 3'b011,
		PJS_CRUISE= 3'b010,
		PJS_DECEL = 3'b110,
		PJS_DWELL = 3'b111
	} pjs_state_e;

endpackage

/* pjs_ms_tick.sv */
`timescale 1ns/1ps
module pjs_ms_tick
#(
	// a shorter tick lets the bench run whole profiles in a few thousand cycles
	parameter int unsigned TICK_CYCLES = pjs_pkg::CYCLES_PER_MS
)
(
	input  wire logic ref_clk,
	input  wire logic rst,
	output logic      ms_tick
);
	logic [17:0] cnt;
	logic [17:0] next_cnt;

	always_comb
	begin
		if (cnt == 18'(TICK_CYCLES - 1))
			next_cnt = '0;
		else
			next_cnt = cnt + 18'h1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			cnt <= '0;
		else
			cnt <= next_cnt;
	end

	assign ms_tick = (cnt == 18'(TICK_CYCLES - 1));
endmodule

/* pjs_motor_model.sv */
`timescale 1ns/1ps
module pjs_motor_model
(
	input  wire logic               ref_clk,
	input  wire logic               rst,
	input  wire logic signed [12:0] speed_ref,
	input  wire logic signed [31:0] pos_ref,
	output logic signed [12:0]      motor_speed,
	output logic signed [31:0]      motor_pos
);
	//------------------------------------------------------------
	// stiff loop
	//------------------------------------------------------------
	// a stiff loop lags by one cycle; softer loops would hide ref glitches
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			motor_speed <= '0;
			motor_pos   <= '0;
		end
		else
		begin
			motor_speed <= speed_ref;
			motor_pos   <= pos_ref;
		end
	end
endmodule

/* program_jog_profile_sequencer_test.sv */
`timescale 1ns/1ps
module program_jog_profile_sequencer_test;
	logic               ref_clk = 1'b0;
	logic               rst = 1'b1;
	logic               util_selected = 1'b0;
	logic               key_shift = 1'b0;
	logic               key_mode = 1'b0;
	logic               param_write_ok = 1'b1;
	logic               main_power_on = 1'b1;
	logic               servo_on = 1'b0;
	logic               safe_state = 1'b0;
	logic               alarm = 1'b0;
	logic               overtravel = 1'b0;
	logic signed [7:0]  t0 = pjs_pkg::TURNS_RST;
	logic signed [7:0]  t1 = pjs_pkg::TURNS_RST;
	logic [11:0]        s0 = pjs_pkg::SPEED_RST;
	logic [11:0]        s1 = pjs_pkg::SPEED_RST;
	logic [10:0]        r0 = pjs_pkg::RAMP_RST;
	logic [10:0]        r1 = pjs_pkg::RAMP_RST;
	logic [13:0]        d0 = pjs_pkg::DWELL_RST;
	logic [13:0]        d1 = pjs_pkg::DWELL_RST;
	logic               util_open, running, refused, pattern_sel, reverse;
	logic signed [12:0] speed_ref, motor_speed;
	logic signed [31:0] pos_ref, motor_pos;
	logic [5:0]         ilk;
	logic               r;
	int                 miscompares = 0;
	int                 check_count = 0;
	int                 seed = 2089;
	int                 i;
	int                 cyc;
	int                 pk0;
	int                 pk1;
	logic               wrong_dir;
	logic               seen1;
	logic signed [31:0] pos_s;
	logic signed [31:0] pos_a;

	// a short millisecond keeps whole profiles inside the run
	localparam int unsigned BENCH_TICK = 8;
	// the last speed step may overshoot a little; a fiftieth of a turn
	localparam int          POS_TOL    = 1200;

	always #2.5 ref_clk = ~ref_clk;

	pjs_sequencer #(.TICK_CYCLES(BENCH_TICK)) dut (.ref_clk(ref_clk),
		.rst(rst),
		.util_selected(util_selected), .key_shift(key_shift),
		.key_mode(key_mode), .param_write_ok(param_write_ok),
		.main_power_on(main_power_on), .servo_on(servo_on),
		.safe_state(safe_state), .alarm(alarm), .overtravel(overtravel),
		.first_pattern_turns(t0), .first_pattern_peak_speed(s0),
		.first_pattern_ramp_time(r0), .first_pattern_dwell_time(d0),
		.second_pattern_turns(t1), .second_pattern_peak_speed(s1),
		.second_pattern_ramp_time(r1), .second_pattern_dwell_time(d1),
		.util_open(util_open), .running(running), .refused(refused),
		.pattern_sel(pattern_sel), .reverse(reverse),
		.speed_ref(speed_ref), .pos_ref(pos_ref));

	pjs_motor_model motor (.ref_clk(ref_clk), .rst(rst),
		.speed_ref(speed_ref), .pos_ref(pos_ref),
		.motor_speed(motor_speed), .motor_pos(motor_pos));

	//------------------------------------------------------------
	// helpers
	//------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// one-cycle key press; refused is combinational so it is caught first
	task automatic press(input logic sel, input logic sh, input logic md,
		output logic ref_seen);
		@(negedge ref_clk);
		util_selected = sel;
		key_shift = sh;
		key_mode = md;
		#1 ref_seen = refused;
		@(negedge ref_clk);
		util_selected = 1'b0;
		key_shift = 1'b0;
		key_mode = 1'b0;
		#1;
	endtask

	task automatic apply(input logic [5:0] f);
		@(negedge ref_clk);
		param_write_ok = ~f[0];
		main_power_on = ~f[1];
		servo_on = f[2];
		safe_state = f[3];
		alarm = f[4];
		overtravel = f[5];
	endtask

	function automatic logic near(input logic signed [31:0] p, input int e);
		int d;
		d = int'(p) - e;
		return d <= POS_TOL && d >= -POS_TOL;
	endfunction

	function automatic logic exp_refused(input logic [5:0] f);
		return |f;
	endfunction

	//------------------------------------------------------------
	// sequence
	//------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		#1;
		check("util_open", util_open, 32'h0);
		check("running", running, 32'h0);
		check("speed_ref", speed_ref, 32'h0);
		for (i = 0; i < 8; i++)
		begin
			@(negedge ref_clk);
			t0 = $random(seed) % 60;
			t1 = $random(seed) % 60;
			s0 = pjs_pkg::SPEED_MIN + 12'($unsigned($random(seed)) % 2901);
			r1 = pjs_pkg::RAMP_MIN + 11'($unsigned($random(seed)) % 1951);
			#1 check("reverse", reverse, {31'h0, t0 < 0});
		end
		press(1'b0, 1'b1, 1'b0, r);
		check("util_open", util_open, 32'h0);
		press(1'b1, 1'b1, 1'b0, r);
		check("util_open", util_open, 32'h1);
		for (i = 0; i < 30; i++)
		begin
			ilk = (i < 6) ? 6'h01 << i : ((i < 8) ? 6'h00 : 6'($random(seed)));
			apply(ilk);
			press(1'b0, 1'b0, 1'b1, r);
			check("refused", r, {31'h0, exp_refused(ilk)});
			check("running", running, {31'h0, ~exp_refused(ilk)});
			if (running === 1'b1)
			begin
				check("pattern_sel", pattern_sel, 32'h0);
				if (i % 2 == 0)
				begin
					apply(6'h04);
					press(1'b0, 1'b0, 1'b0, r);
					check("fault stop", running, 32'h0);
					check("fault open", util_open, 32'h1);
					check("fault speed", speed_ref, 32'h0);
				end
				else
				begin
					press(1'b0, 1'b1, 1'b0, r);
					check("shift exit", util_open, 32'h0);
					check("shift stop", running, 32'h0);
					press(1'b1, 1'b1, 1'b0, r);
				end
			end
		end
		// whole pair: a forward trapezoid, then a reverse short triangle
		@(negedge ref_clk);
		t0 = 8'sd1;
		s0 = pjs_pkg::SPEED_RST;
		r0 = pjs_pkg::RAMP_MIN;
		d0 = pjs_pkg::DWELL_MIN;
		t1 = -8'sd1;
		s1 = pjs_pkg::SPEED_MAX;
		r1 = pjs_pkg::RAMP_MIN;
		d1 = pjs_pkg::DWELL_MIN;
		apply(6'h00);
		pos_s = pos_ref;
		pk0 = 0;
		pk1 = 0;
		wrong_dir = 1'b0;
		seen1 = 1'b0;
		pos_a = pos_s;
		press(1'b0, 1'b0, 1'b1, r);
		check("motion start", running, 32'h1);
		for (cyc = 0; cyc < 4000; cyc++)
		begin
			@(negedge ref_clk);
			#1;
			if (pattern_sel === 1'b1)
			begin
				seen1 = 1'b1;
				if (speed_ref > 0)
					wrong_dir = 1'b1;
				if (-int'(speed_ref) > pk1)
					pk1 = -int'(speed_ref);
			end
			else if (seen1)
				break;
			else
			begin
				pos_a = pos_ref;
				if (speed_ref < 0)
					wrong_dir = 1'b1;
				if (int'(speed_ref) > pk0)
					pk0 = int'(speed_ref);
			end
		end
		check("pair done", {31'h0, seen1 && cyc < 4000}, 32'h1);
		check("cruise peak", pk0, 32'(pjs_pkg::SPEED_RST));
		check("short peak", {31'h0, pk1 > 0 && pk1 < pjs_pkg::SPEED_MAX},
			32'h1);
		check("direction", {31'h0, wrong_dir}, 32'h0);
		check("fwd travel", {31'h0, near(pos_a - pos_s,
			int'(pjs_pkg::POS_PER_TURN))}, 32'h1);
		check("back travel", {31'h0, near(pos_ref - pos_s, 0)},
			32'h1);
		check("motor follows", motor_pos, pos_ref);
		apply(6'h00);
		press(1'b1, 1'b1, 1'b1, r);
		check("shift first", util_open, 32'h0);
		check("shift first run", running, 32'h0);
		check("motor pos", motor_pos, pos_ref);
		final_report();
	end

	initial
	begin
		// the motion pair needs about 3000 cycles on top of the key tests
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		final_report();
	end
endmodule
